// ===== inc/arsf_consts.svh
// register offsets, field positions and reset values of the receive status bank
`ifndef ARSF_CONSTS_SVH
`define ARSF_CONSTS_SVH

// byte addresses on the register port
`define ARSF_ADDR_STATUS 8'h00
`define ARSF_ADDR_ENABLE 8'h04
`define ARSF_ADDR_CLEAR 8'h08

// flag positions inside the status word
`define ARSF_BIT_OVRN 0
`define ARSF_BIT_EARLY 1
`define ARSF_BIT_CKFAIL 2
`define ARSF_BIT_PARITY 3
`define ARSF_BIT_LAST 4
`define ARSF_BIT_DATA 5
`define ARSF_BIT_FRAME 6
`define ARSF_BIT_HOSTERR 7
`define ARSF_BIT_SUMMARY 8

// flags that hardware sets and software clears; bit 3 is read-only
`define ARSF_FLAG_MASK 8'hf7
// flags that feed the error summary
`define ARSF_ERR_MASK 8'h87

// reset values
`define ARSF_STATUS_RST 8'h00
`define ARSF_ENABLE_RST 8'h00
`define ARSF_RDATA_RST 32'h0000_0000

// width of the serializer read counter
`define ARSF_SER_W 5

`endif

// ===== inc/arsf_pkg.sv
// types shared by the receive status bank modules
`default_nettype none

package arsf_pkg;

	// one bit per status flag, laid out as the status word bits 7..0
	typedef logic [7:0] arsf_flags_t;

	// complete state of the status bank
	typedef struct packed {
		arsf_flags_t flags;
		arsf_flags_t enable;
		logic [31:0] rdata;
		logic irq;
		logic irq_req;
		logic dma_req;
	} arsf_state_s;

	// complete state of the per-slot read checker
	typedef struct packed {
		logic [4:0] reads;
		logic err;
	} arsf_chk_s;

endpackage

`default_nettype wire

// ===== core/arsf_read_check.sv
// per-slot data port read counter that flags excess host reads
`default_nettype none
`include "arsf_consts.svh"

module arsf_read_check
	import arsf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_sync_n,
	input wire logic slot_start,
	input wire logic host_dp_read,
	input wire logic [4:0] rx_ser_count,
	output logic read_error
);

	arsf_chk_s st_q;
	arsf_chk_s st_d;

	// ****************************************************************
	// read counting
	// ****************************************************************

	// a read in the slot-start cycle belongs to the new slot
	always_comb begin
		logic [4:0] base;
		base = slot_start ? 5'h00 : st_q.reads;
		st_d = st_q;
		st_d.err = 1'b0;
		st_d.reads = base;
		if (host_dp_read) begin
			// more reads than receivers in this slot [RULE_04]
			st_d.err = (base >= rx_ser_count);
			// saturate so a runaway host cannot wrap back under the limit
			if (base != 5'h1f) begin
				st_d.reads = base + 5'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign read_error = st_q.err;

	// one read beyond the configured receivers must flag
	chk_excess_read_flags: assert property ( // [RULE_04]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(host_dp_read && !slot_start && st_q.reads >= rx_ser_count) |=> read_error
	) else $error("excess host read not flagged");

	// reads within the budget never flag
	chk_legal_read_quiet: assert property ( // [RULE_04]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(host_dp_read && !slot_start && st_q.reads < rx_ser_count) |=> !read_error
	) else $error("legal host read flagged");

endmodule

`default_nettype wire

// ===== core/arsf_status.sv
// receive status flags, interrupt and dma event logic of the audio port
//
// Behaviour
// RULE_01: hardware set beats same-cycle software clear
// RULE_02: collision also raises a fresh interrupt request
// RULE_03: bit 8 is OR of error flags
// RULE_04: excess data port reads per slot flag error
// RULE_05: interrupt while any enabled flag set
// RULE_06: flags clear on write one only
// RULE_07: frame sync sets frame start flag
// RULE_08: word into buffer sets data ready
// RULE_09: every data ready set issues dma event
// RULE_10: last slot flag set with data ready
// RULE_11: bit 3 returns slot counter lsb
// RULE_12: parity bit zero odd, one even
// RULE_13: bits 31 to 9 read zero
// RULE_14: buffer overwrite sets overrun flag
// RULE_15: early frame sync sets sync error flag
// RULE_16: clock failure report sets clock fail flag
//
// Chosen here: the register addresses and the address-and-strobe port.
`default_nettype none
`include "arsf_consts.svh"

module arsf_status
	import arsf_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ev_overrun,
	input wire logic ev_early_sync,
	input wire logic ev_clock_fail,
	input wire logic rx_frame_sync,
	input wire logic ev_word_moved,
	input wire logic ev_slot_is_last,
	input wire logic slot_start,
	input wire logic host_dp_read,
	input wire logic [4:0] rx_ser_count,
	input wire logic [9:0] rx_slot_counter,
	output logic rx_interrupt,
	output logic rx_int_request,
	output logic rx_dma_request
);

	// ****************************************************************
	// reset release
	// ****************************************************************

	logic [1:0] rst_pipe_q;
	logic rst_sync_n;

	// assert at once, release two edges later so all flops leave together
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_q <= 2'b00;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end

	assign rst_sync_n = rst_pipe_q[1];

	// ****************************************************************
	// helpers
	// ****************************************************************

	// address match, used by every strobe decode
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	// assemble the status word from flags and the slot counter lsb
	function automatic logic [31:0] status_word(input arsf_flags_t f, input logic par);
		logic [31:0] w;
		w = 32'h0000_0000; // reserved bits stay zero [RULE_13]
		w[7:0] = f & `ARSF_FLAG_MASK;
		w[`ARSF_BIT_PARITY] = par; // [RULE_11]
		w[`ARSF_BIT_SUMMARY] = |(f & `ARSF_ERR_MASK); // [RULE_03]
		return w;
	endfunction

	// ****************************************************************
	// host read checker
	// ****************************************************************

	logic host_err;

	arsf_read_check u_read_check (
		.sys_clk(sys_clk),
		.rst_sync_n(rst_sync_n),
		.slot_start(slot_start),
		.host_dp_read(host_dp_read),
		.rx_ser_count(rx_ser_count),
		.read_error(host_err)
	);

	// ****************************************************************
	// register port decode
	// ****************************************************************

	logic wr_status;
	logic wr_enable;
	logic wr_clear;
	logic [7:0] clr_mask;
	arsf_flags_t set_vec;
	arsf_flags_t fresh_vec;

	// writes to status and to the clear register both clear by ones
	assign wr_status = reg_wr && addr_is(reg_addr, `ARSF_ADDR_STATUS);
	assign wr_enable = reg_wr && addr_is(reg_addr, `ARSF_ADDR_ENABLE);
	assign wr_clear = reg_wr && addr_is(reg_addr, `ARSF_ADDR_CLEAR);
	assign clr_mask = (wr_status || wr_clear) ? (reg_wdata[7:0] & `ARSF_FLAG_MASK) : 8'h00;

	// ****************************************************************
	// flag set events
	// ****************************************************************

	// hardware events mapped onto their flag positions
	always_comb begin
		set_vec = 8'h00;
		set_vec[`ARSF_BIT_OVRN] = ev_overrun; // [RULE_14]
		set_vec[`ARSF_BIT_EARLY] = ev_early_sync; // [RULE_15]
		set_vec[`ARSF_BIT_CKFAIL] = ev_clock_fail; // [RULE_16]
		set_vec[`ARSF_BIT_LAST] = ev_word_moved && ev_slot_is_last; // [RULE_10]
		set_vec[`ARSF_BIT_DATA] = ev_word_moved; // [RULE_08]
		set_vec[`ARSF_BIT_FRAME] = rx_frame_sync; // [RULE_07]
		set_vec[`ARSF_BIT_HOSTERR] = host_err; // [RULE_04]
	end

	// ****************************************************************
	// state
	// ****************************************************************

	arsf_state_s st_q;
	arsf_state_s st_d;

	// a set counts as new when the flag was clear or is being cleared now
	assign fresh_vec = set_vec & (~st_q.flags | clr_mask); // [RULE_02]

	// next state of the whole bank
	always_comb begin
		st_d = st_q;
		// clear only where a one is written, then set wins [RULE_06] [RULE_01]
		st_d.flags = ((st_q.flags & ~clr_mask) | set_vec) & `ARSF_FLAG_MASK;
		if (wr_enable) begin
			st_d.enable = reg_wdata[7:0] & `ARSF_FLAG_MASK;
		end
		// level follows next flags so it moves in the same edge as the flag
		st_d.irq = |(st_d.flags & st_d.enable); // [RULE_05]
		// pulse per new or colliding enabled set, for edge-driven controllers
		st_d.irq_req = |(fresh_vec & st_q.enable); // [RULE_02]
		// every data ready set is a dma event, mask not consulted [RULE_09]
		st_d.dma_req = ev_word_moved;
		// read data stand for one cycle only, zero otherwise
		st_d.rdata = `ARSF_RDATA_RST;
		if (reg_rd) begin
			if (addr_is(reg_addr, `ARSF_ADDR_STATUS)) begin
				// parity is the counter lsb; slot n is counter n-1 [RULE_11] [RULE_12]
				st_d.rdata = status_word(st_q.flags, rx_slot_counter[0]);
			end else if (addr_is(reg_addr, `ARSF_ADDR_ENABLE)) begin
				st_d.rdata = {24'h00_0000, st_q.enable};
			end else begin
				// clear register and unmapped addresses read zero
				st_d.rdata = `ARSF_RDATA_RST;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_q <= '{flags: `ARSF_STATUS_RST, enable: `ARSF_ENABLE_RST,
				rdata: `ARSF_RDATA_RST, default: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// outputs come straight from the state flops
	assign reg_rdata = st_q.rdata;
	assign rx_interrupt = st_q.irq;
	assign rx_int_request = st_q.irq_req;
	assign rx_dma_request = st_q.dma_req;

	// ****************************************************************
	// checks
	// ****************************************************************

	// set and write-one on the same flag leaves it set
	chk_set_beats_clear: assert property ( // [RULE_01]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(ev_overrun && wr_status && reg_wdata[`ARSF_BIT_OVRN])
		|=> st_q.flags[`ARSF_BIT_OVRN]
	) else $error("clear won over hardware set");

	// same collision through the clear register, data ready flag
	chk_set_beats_wclr: assert property ( // [RULE_01]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(ev_word_moved && wr_clear && reg_wdata[`ARSF_BIT_DATA])
		|=> st_q.flags[`ARSF_BIT_DATA]
	) else $error("clear register won over data ready");

	// collision on an enabled flag gives a request pulse
	chk_collide_request: assert property ( // [RULE_02]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(rx_frame_sync && st_q.flags[`ARSF_BIT_FRAME] && st_q.enable[`ARSF_BIT_FRAME]
			&& wr_status && reg_wdata[`ARSF_BIT_FRAME])
		|=> rx_int_request
	) else $error("collision gave no interrupt request");

	// a set on an already set, uncleared flag is not a new request
	chk_repeat_quiet: assert property ( // [RULE_02]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(fresh_vec == 8'h00) |=> !rx_int_request
	) else $error("request without a fresh set");

	// a newly set enabled flag always gives a request pulse
	chk_fresh_request: assert property ( // [RULE_02]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		((set_vec & ~st_q.flags & st_q.enable) != 8'h00) |=> rx_int_request
	) else $error("new enabled flag gave no request");

	// summary bit of a status read is the OR of the error flags
	chk_summary_or: assert property ( // [RULE_03]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(reg_rd && addr_is(reg_addr, `ARSF_ADDR_STATUS))
		|=> reg_rdata[`ARSF_BIT_SUMMARY] == (reg_rdata[`ARSF_BIT_HOSTERR]
			|| reg_rdata[`ARSF_BIT_CKFAIL] || reg_rdata[`ARSF_BIT_EARLY]
			|| reg_rdata[`ARSF_BIT_OVRN])
	) else $error("error summary wrong");

	// excess read reaches the status flag two edges on
	chk_host_err_flag: assert property ( // [RULE_04]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		host_err |=> st_q.flags[`ARSF_BIT_HOSTERR]
	) else $error("host read error flag not set");

	// interrupt level tracks enabled flags at every edge
	chk_irq_level: assert property ( // [RULE_05]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		rx_interrupt == |(st_q.flags & st_q.enable)
	) else $error("interrupt level mismatch");

	// writing zero to a set flag keeps it
	chk_zero_keeps: assert property ( // [RULE_06]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(wr_status && !reg_wdata[`ARSF_BIT_LAST] && st_q.flags[`ARSF_BIT_LAST])
		|=> st_q.flags[`ARSF_BIT_LAST]
	) else $error("write of zero cleared a flag");

	// writing one with no event clears
	chk_one_clears: assert property ( // [RULE_06]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(wr_clear && reg_wdata[`ARSF_BIT_HOSTERR] && !host_err)
		|=> !st_q.flags[`ARSF_BIT_HOSTERR]
	) else $error("write of one did not clear");

	// writing one through the status address with no event clears
	chk_status_clears: assert property ( // [RULE_06]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(wr_status && reg_wdata[`ARSF_BIT_FRAME] && !rx_frame_sync)
		|=> !st_q.flags[`ARSF_BIT_FRAME]
	) else $error("status write of one did not clear");

	// frame sync sets the frame start flag
	chk_frame_set: assert property ( // [RULE_07]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		rx_frame_sync |=> st_q.flags[`ARSF_BIT_FRAME]
	) else $error("frame start flag not set");

	// moved word sets data ready and the dma event together
	chk_data_dma: assert property ( // [RULE_08] [RULE_09]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		ev_word_moved |=> (st_q.flags[`ARSF_BIT_DATA] && rx_dma_request)
	) else $error("data ready or dma event missing");

	// no dma event without a moved word
	chk_dma_only_data: assert property ( // [RULE_09]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		!ev_word_moved |=> !rx_dma_request
	) else $error("spurious dma event");

	// last slot flag never rises without data ready
	chk_last_with_data: assert property ( // [RULE_10]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		$rose(st_q.flags[`ARSF_BIT_LAST]) |-> (rx_dma_request && st_q.flags[`ARSF_BIT_DATA])
	) else $error("last slot set without data ready");

	// data ready never rises without its dma event
	chk_data_rise_dma: assert property ( // [RULE_09]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		$rose(st_q.flags[`ARSF_BIT_DATA]) |-> rx_dma_request
	) else $error("data ready set without dma event");

	// parity bit equals counter lsb of the read cycle
	chk_parity_bit: assert property ( // [RULE_11] [RULE_12]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(reg_rd && addr_is(reg_addr, `ARSF_ADDR_STATUS))
		|=> reg_rdata[`ARSF_BIT_PARITY] == $past(rx_slot_counter[0])
	) else $error("slot parity bit wrong");

	// reserved bits 31 to 9 of the read data are zero at every edge
	chk_reserved_zero: assert property ( // [RULE_13]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		reg_rdata[31:9] == 23'h00_0000
	) else $error("reserved bits nonzero");

	// read data only in the cycle after a read strobe
	chk_rdata_once: assert property (
		@(posedge sys_clk) disable iff (!rst_sync_n)
		!reg_rd |=> reg_rdata == 32'h0000_0000
	) else $error("read data outside its cycle");

	// the write-only clear register reads zero
	chk_clear_reads_zero: assert property (
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(reg_rd && addr_is(reg_addr, `ARSF_ADDR_CLEAR)) |=> reg_rdata == 32'h0000_0000
	) else $error("clear register read nonzero");

	// error events set their flags
	chk_error_flags: assert property ( // [RULE_14] [RULE_15] [RULE_16]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(ev_overrun || ev_early_sync || ev_clock_fail)
		|=> (st_q.flags & `ARSF_ERR_MASK) != 8'h00
	) else $error("error flag not set");

	// each error flag individually
	chk_ovrn_set: assert property ( // [RULE_14]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		ev_overrun |=> st_q.flags[`ARSF_BIT_OVRN]
	) else $error("overrun flag not set");

	chk_early_set: assert property ( // [RULE_15]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		ev_early_sync |=> st_q.flags[`ARSF_BIT_EARLY]
	) else $error("early sync flag not set");

	chk_ckfail_set: assert property ( // [RULE_16]
		@(posedge sys_clk) disable iff (!rst_sync_n)
		ev_clock_fail |=> st_q.flags[`ARSF_BIT_CKFAIL]
	) else $error("clock fail flag not set");

endmodule

`default_nettype wire

// ===== testbench/arsf_host_model.sv
// behavioural host that reads the receive data port in bursts
`default_nettype none

module arsf_host_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic slow,
	input wire logic [4:0] reads,
	output logic host_dp_read
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] left_q;
	logic gap_q;
	// slow mode idles every other cycle, like a stalled dma channel
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			left_q <= 5'h00;
			gap_q <= 1'b0;
		end else if (go) begin
			left_q <= reads; // reads per slot chosen by the bench
			gap_q <= 1'b0;
		end else if (host_dp_read) begin
			left_q <= left_q - 5'h01;
			gap_q <= slow;
		end else begin
			gap_q <= 1'b0;
		end
	end
	// one read strobe per cycle while the burst lasts, none in the gap cycles of slow mode
	assign host_dp_read = (left_q != 5'h00) && !gap_q;
endmodule

`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the receive status flag bank
`default_nettype none
`include "arsf_consts.svh"

module testbench import arsf_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, rst_n, reg_wr, reg_rd, slot_start, go, slow, host_dp_read;
	logic rx_interrupt, rx_int_request, rx_dma_request;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v, en, clr;
	logic [5:0] ev, ev_r;
	logic [4:0] nrd, rx_ser_count;
	logic [9:0] rx_slot_counter;
	arsf_flags_t exp;
	int mismatches, checks_done, n_dma, n_irq, n0, i;

	arsf_status i_arsf_status (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ev_overrun(ev[0]), .ev_early_sync(ev[1]), .ev_clock_fail(ev[2]),
		.rx_frame_sync(ev[3]), .ev_word_moved(ev[4]), .ev_slot_is_last(ev[5]),
		.slot_start(slot_start), .host_dp_read(host_dp_read), .rx_ser_count(rx_ser_count),
		.rx_slot_counter(rx_slot_counter), .rx_interrupt(rx_interrupt),
		.rx_int_request(rx_int_request), .rx_dma_request(rx_dma_request));
	arsf_host_model i_arsf_host_model (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
		.slow(slow), .reads(nrd), .host_dp_read(host_dp_read));

	// ************************************************
	// clock, pulse counters and helpers
	// ************************************************
	always #5 sys_clk = ~sys_clk;
	// non-blocking so readers at the same edge never race the count
	always @(posedge sys_clk) begin
		if (rx_dma_request === 1'b1) n_dma <= n_dma + 1;
		if (rx_int_request === 1'b1) n_irq <= n_irq + 1;
	end
	function automatic arsf_flags_t ev_flags(input logic [5:0] e);
		ev_flags = {1'b0, e[3], e[4], e[4] & e[5], 1'b0, e[2:0]};
	endfunction
	function automatic logic [31:0] stat_word(input arsf_flags_t f, input logic par);
		stat_word = {23'h0, |(f & `ARSF_ERR_MASK), f[7:4], par, f[2:0]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			mismatches++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	// all bus tasks start and end right after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic pulse(input logic [5:0] e);
		ev <= e;
		@(posedge sys_clk);
		ev <= 6'h00;
		@(posedge sys_clk);
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// watchdog: a hang is counted as a mismatch
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		end_of_test();
	end

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		{sys_clk, rst_n, reg_wr, reg_rd, slot_start, go, slow, ev} = '0;
		{reg_addr, reg_wdata, nrd, rx_ser_count, rx_slot_counter} = '0;
		{n_dma, n_irq} = '0;
		void'($urandom(66));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(`ARSF_ADDR_STATUS, v);
		chk(v, 32'h0);
		rd(`ARSF_ADDR_ENABLE, v);
		chk(v, 32'h0);
		rd(`ARSF_ADDR_CLEAR, v);
		chk(v, 32'h0);
		done("reset");
		// each event alone (slot-is-last together with a moved word), then write 0 / reserved, then clear by both paths
		for (i = 0; i < 6; i++) begin
			pulse(i == 5 ? 6'h30 : 6'h01 << i);
			exp = ev_flags(i == 5 ? 6'h30 : 6'h01 << i);
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, stat_word(exp, 1'b0));
			wr(`ARSF_ADDR_STATUS, 32'hffff_ff00);
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, stat_word(exp, 1'b0));
			wr(i[0] ? `ARSF_ADDR_CLEAR : `ARSF_ADDR_STATUS, {24'h0, exp});
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, 32'h0);
		end
		done("event flags");
		// random events, enables and clears against a running model
		exp = 8'h00;
		for (i = 0; i < 24; i++) begin
			en = $urandom;
			clr = $urandom;
			wr(`ARSF_ADDR_ENABLE, en);
			rd(`ARSF_ADDR_ENABLE, v);
			chk(v, {24'h0, en[7:0] & `ARSF_FLAG_MASK});
			ev_r = 6'($urandom);
			pulse(ev_r);
			exp = exp | ev_flags(ev_r);
			wr(`ARSF_ADDR_STATUS, clr);
			exp = exp & ~clr[7:0];
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, stat_word(exp, 1'b0));
			chk(rx_interrupt, |(exp & en[7:0]));
		end
		wr(`ARSF_ADDR_ENABLE, 32'h0);
		#1 chk(rx_interrupt, 1'b0);
		wr(`ARSF_ADDR_CLEAR, 32'hff);
		done("random mix");
		// set and clear in one cycle: overrun and frame start via status,
		// data ready via the clear register; idle edge so the strobe drops first
		@(posedge sys_clk);
		for (i = 0; i < 3; i++) begin
			ev_r = (i == 0) ? 6'h01 : ((i == 1) ? 6'h10 : 6'h08);
			exp = ev_flags(ev_r);
			wr(`ARSF_ADDR_ENABLE, {24'h0, exp});
			pulse(ev_r);
			// let the first request reach the pulse counter before taking the base
			@(posedge sys_clk);
			n0 = n_irq;
			reg_addr <= i[0] ? `ARSF_ADDR_CLEAR : `ARSF_ADDR_STATUS;
			reg_wdata <= {24'h0, exp};
			reg_wr <= 1'b1;
			ev <= ev_r;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
			ev <= 6'h00;
			repeat (3) @(posedge sys_clk);
			chk(n_irq - n0, 1);
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, stat_word(exp, 1'b0));
			chk(rx_interrupt, 1'b1);
			wr(`ARSF_ADDR_CLEAR, {24'h0, exp});
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, 32'h0);
		end
		wr(`ARSF_ADDR_ENABLE, 32'h0);
		done("collision");
		// back-to-back words, each a dma event with interrupts masked
		n0 = n_dma;
		ev <= 6'h10;
		repeat (5) @(posedge sys_clk);
		ev <= 6'h00;
		repeat (3) @(posedge sys_clk);
		chk(n_dma - n0, 5);
		wr(`ARSF_ADDR_CLEAR, 32'hff);
		done("dma event");
		// host reads up to the receiver count, then one too many
		for (i = 0; i < 2; i++) begin
			rx_ser_count <= 5'($urandom_range(4, 1));
			slow <= i[0];
			slot_start <= 1'b1;
			@(posedge sys_clk);
			slot_start <= 1'b0;
			nrd <= rx_ser_count;
			go <= 1'b1;
			@(posedge sys_clk);
			go <= 1'b0;
			repeat (14) @(posedge sys_clk);
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, 32'h0);
			nrd <= 5'h01;
			go <= 1'b1;
			@(posedge sys_clk);
			go <= 1'b0;
			repeat (5) @(posedge sys_clk);
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, 32'h180);
			wr(`ARSF_ADDR_STATUS, 32'h80);
		end
		done("host read error");
		// slot parity follows the counter lsb
		for (i = 0; i < 8; i++) begin
			rx_slot_counter <= 10'($urandom_range(383));
			@(posedge sys_clk);
			rd(`ARSF_ADDR_STATUS, v);
			chk(v, stat_word(8'h00, rx_slot_counter[0]));
		end
		done("slot parity");
		end_of_test();
	end
endmodule

`default_nettype wire
